// [include/op_status_pkg.sv]
// operation status group constants: register selects, bit positions, reset values
// assumes a command parser outside that decodes status commands into selects
package op_status_pkg;
  localparam int          REG_W          = 16;
  localparam int          BIT_PROG_RUN   = 14;
  localparam int          BIT_CALL_SUM   = 9;
  localparam logic [15:0] USED_MASK      = 16'h4200;
  localparam logic [15:0] RISE_RESET     = 16'hffff;
  localparam logic [15:0] FALL_RESET     = 16'h0000;
  localparam logic [15:0] ENABLE_RESET   = 16'h0000;
  // register selects carried by the command strobe
  localparam logic [2:0]  SEL_CONDITION  = 3'h0;
  localparam logic [2:0]  SEL_RISE       = 3'h1;
  localparam logic [2:0]  SEL_FALL       = 3'h2;
  localparam logic [2:0]  SEL_EVENT      = 3'h3;
  localparam logic [2:0]  SEL_ENABLE     = 3'h4;
endpackage : op_status_pkg

// [hw/op_edge_latch.sv]
// edge-filtered sticky event latch for the operation status group
// assumes condition bits are synchronous to clk_i
`timescale 1ns/100ps
module op_edge_latch #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] cond_i,
  input  wire logic [WIDTH-1:0] rise_mask_i,
  input  wire logic [WIDTH-1:0] fall_mask_i,
  input  wire logic             clear_i,
  output logic      [WIDTH-1:0] event_o
);
  logic [WIDTH-1:0] cond_prev;
  logic [WIDTH-1:0] event_q;
  logic [WIDTH-1:0] next_cond_prev;
  logic [WIDTH-1:0] next_event;
  logic [WIDTH-1:0] hit;

  always_comb begin
    next_cond_prev = cond_i;
    hit = (cond_i & ~cond_prev & rise_mask_i)
        | (~cond_i & cond_prev & fall_mask_i);
    // a transition in the clear cycle is kept: set beats clear
    next_event = (clear_i ? '0 : event_q) | hit;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cond_prev <= '0;
      event_q   <= '0;
    end else begin
      cond_prev <= next_cond_prev;
      event_q   <= next_event;
    end
  end

  assign event_o = event_q;
endmodule : op_edge_latch

// [hw/op_status_group.sv]
// operation status register group: condition, edge filters, event, enable, summary
// assumes a command parser issues one-cycle strobes with a register select
`timescale 1ns/100ps
module op_status_group
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        prog_running_i,
  input  wire logic        call_summary_i,
  input  wire logic        cmd_write_i,
  input  wire logic        cmd_query_i,
  input  wire logic [2:0]  cmd_sel_i,
  input  wire logic [15:0] cmd_wdata_i,
  input  wire logic        clear_status_i,
  input  wire logic        reset_cmd_i,
  output logic             resp_valid_o,
  output logic      [15:0] resp_data_o,
  output logic             summary_o
);
  import op_status_pkg::*;

  // ***********************************
  // condition and event latch
  // ***********************************
  logic [15:0] condition;
  logic [15:0] event_bits;
  logic [15:0] rising_edge_filter;
  logic [15:0] falling_edge_filter;
  logic [15:0] enable;
  logic        ev_clear;

  always_comb begin
    condition               = '0;
    condition[BIT_PROG_RUN] = prog_running_i;
    condition[BIT_CALL_SUM] = call_summary_i;
  end

  // event query clears only after its value is captured into the response
  assign ev_clear = clear_status_i | (cmd_query_i && cmd_sel_i == SEL_EVENT);

  op_edge_latch #(.WIDTH(REG_W)) u_latch (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .cond_i      (condition),
    .rise_mask_i (rising_edge_filter & USED_MASK),
    .fall_mask_i (falling_edge_filter & USED_MASK),
    .clear_i     (ev_clear),
    .event_o     (event_bits)
  );

  // ***********************************
  // writable registers
  // ***********************************
  logic [15:0] next_rise;
  logic [15:0] next_fall;
  logic [15:0] next_enable;

  always_comb begin
    next_rise   = rising_edge_filter;
    next_fall   = falling_edge_filter;
    next_enable = enable;
    if (cmd_write_i) begin
      unique case (cmd_sel_i)
        SEL_RISE:   next_rise   = cmd_wdata_i;
        SEL_FALL:   next_fall   = cmd_wdata_i;
        SEL_ENABLE: next_enable = cmd_wdata_i & USED_MASK;
        default: ;
      endcase
    end
    // reset command wins over a filter write in the same cycle; enable and clear-status not involved
    if (reset_cmd_i) begin
      next_rise = RISE_RESET;
      next_fall = FALL_RESET;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rising_edge_filter  <= RISE_RESET;
      falling_edge_filter <= FALL_RESET;
      enable              <= ENABLE_RESET;
    end else begin
      rising_edge_filter  <= next_rise;
      falling_edge_filter <= next_fall;
      enable              <= next_enable;
    end
  end

  // ***********************************
  // query response
  // ***********************************
  logic        next_resp_valid;
  logic [15:0] next_resp_data;

  always_comb begin
    next_resp_valid = cmd_query_i;
    next_resp_data  = resp_data_o;
    if (cmd_query_i) begin
      unique case (cmd_sel_i)
        SEL_CONDITION: next_resp_data = condition;
        SEL_RISE:      next_resp_data = rising_edge_filter;
        SEL_FALL:      next_resp_data = falling_edge_filter;
        SEL_EVENT:     next_resp_data = event_bits;
        SEL_ENABLE:    next_resp_data = enable;
        default:       next_resp_data = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resp_valid_o <= 1'b0;
      resp_data_o  <= '0;
    end else begin
      resp_valid_o <= next_resp_valid;
      resp_data_o  <= next_resp_data;
    end
  end

  assign summary_o = |(event_bits & enable);

  // ***********************************
  // assertions
  // ***********************************
  property p_unused_zero;
    @(posedge clk_i) disable iff (!resetn_i)
      ((event_bits | enable) & ~USED_MASK) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

  property p_cond_query;
    @(posedge clk_i) disable iff (!resetn_i)
      (cmd_query_i && cmd_sel_i == SEL_CONDITION) |=> resp_valid_o
        && resp_data_o == {1'b0, $past(prog_running_i), 4'h0, $past(call_summary_i), 9'h000};
  endproperty
  a_cond_query: assert property (p_cond_query) else $error("bad condition reply");

  property p_rise_set;
    @(posedge clk_i) disable iff (!resetn_i)
      ($rose(prog_running_i) && rising_edge_filter[BIT_PROG_RUN])
        |=> event_bits[BIT_PROG_RUN];
  endproperty
  a_rise_set: assert property (p_rise_set) else $error("rising event lost");

  property p_fall_set;
    @(posedge clk_i) disable iff (!resetn_i)
      ($fell(call_summary_i) && falling_edge_filter[BIT_CALL_SUM])
        |=> event_bits[BIT_CALL_SUM];
  endproperty
  a_fall_set: assert property (p_fall_set) else $error("falling event lost");

  property p_clear;
    @(posedge clk_i) disable iff (!resetn_i)
      (clear_status_i && !$changed(condition)) |=> event_bits == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear-status missed");

  property p_event_query;
    @(posedge clk_i) disable iff (!resetn_i)
      (cmd_query_i && cmd_sel_i == SEL_EVENT) |=> resp_data_o == $past(event_bits);
  endproperty
  a_event_query: assert property (p_event_query) else $error("event reply wrong");

  property p_write_back;
    @(posedge clk_i) disable iff (!resetn_i)
      (cmd_write_i && cmd_sel_i == SEL_FALL && !reset_cmd_i)
        |=> falling_edge_filter == $past(cmd_wdata_i);
  endproperty
  a_write_back: assert property (p_write_back) else $error("filter not stored");

  property p_reset_cmd;
    @(posedge clk_i) disable iff (!resetn_i)
      reset_cmd_i |=> rising_edge_filter == RISE_RESET && falling_edge_filter == FALL_RESET;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("filters not reset");

  property p_enable_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      !(cmd_write_i && cmd_sel_i == SEL_ENABLE) |=> $stable(enable);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable drifted");

  property p_summary;
    @(posedge clk_i) disable iff (!resetn_i)
      summary_o == ((event_bits[BIT_PROG_RUN] && enable[BIT_PROG_RUN])
                 || (event_bits[BIT_CALL_SUM] && enable[BIT_CALL_SUM]));
  endproperty
  a_summary: assert property (p_summary) else $error("summary wrong");

  // the latched call-summary bit may only drop through a clear; further edges must not toggle it
  property p_sticky;
    @(posedge clk_i) disable iff (!resetn_i)
      (event_bits[BIT_CALL_SUM] && !ev_clear) |=> event_bits[BIT_CALL_SUM];
  endproperty
  a_sticky: assert property (p_sticky) else $error("event bit dropped");

  property p_resp_pulse;
    @(posedge clk_i) disable iff (!resetn_i)
      !cmd_query_i |=> !resp_valid_o;
  endproperty
  a_resp_pulse: assert property (p_resp_pulse) else $error("reply without query");

  c_rise_event: cover property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(event_bits[BIT_PROG_RUN]));
  c_summary: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(summary_o));
  c_ev_query: cover property (@(posedge clk_i) disable iff (!resetn_i)
    cmd_query_i && cmd_sel_i == SEL_EVENT && event_bits != 16'h0000);
  c_clear_set: cover property (@(posedge clk_i) disable iff (!resetn_i)
    clear_status_i && event_bits != 16'h0000);
endmodule : op_status_group

// [sim/op_host_model.sv]
// host model: issues status commands to the group as one-cycle strobes
// assumes replies come back on resp_valid_i within a few clocks
`timescale 1ns/100ps
module op_host_model (
  input  wire logic        clk_i,
  input  wire logic        resp_valid_i,
  input  wire logic [15:0] resp_data_i,
  output logic             cmd_write_o,
  output logic             cmd_query_o,
  output logic      [2:0]  cmd_sel_o,
  output logic      [15:0] cmd_wdata_o,
  output logic             clear_status_o,
  output logic             reset_cmd_o
);
  // ****************************
  // command tasks
  // ****************************
  initial begin
    {cmd_write_o, cmd_query_o, clear_status_o, reset_cmd_o} = 4'h0;
    cmd_sel_o   = 3'h7;
    cmd_wdata_o = 16'h0;
  end
  // data is inverted after the strobe so a stale word can never pass for a write
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk_i);
    cmd_write_o <= 1'b1;
    cmd_sel_o   <= s;
    cmd_wdata_o <= d;
    @(posedge clk_i);
    cmd_write_o <= 1'b0;
    cmd_wdata_o <= ~d;
  endtask : wr
  task automatic qry(input logic [2:0] s, output logic [15:0] d);
    d = 'x;
    @(posedge clk_i);
    cmd_query_o <= 1'b1;
    cmd_sel_o   <= s;
    @(posedge clk_i);
    cmd_query_o <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (resp_valid_i === 1'b1) begin
        d = resp_data_i;
        break;
      end
      @(posedge clk_i);
    end
  endtask : qry
  task automatic clr(input logic rst);
    @(posedge clk_i);
    if (rst) reset_cmd_o <= 1'b1;
    else clear_status_o <= 1'b1;
    @(posedge clk_i);
    {reset_cmd_o, clear_status_o} <= 2'b00;
  endtask : clr
endmodule : op_host_model

// [sim/op_status_group_tb_top.sv]
// self-checking bench for the operation status group, random with a fixed seed
// assumes op_host_model drives the command port
`timescale 1ns/100ps
module op_status_group_tb_top;
  import op_status_pkg::*;
  logic        clk_i = 1'b0, resetn_i = 1'b0, prog = 1'b0, call = 1'b0;
  logic        cmd_write, cmd_query, clear_status, reset_cmd, resp_valid, summary;
  logic [2:0]  cmd_sel;
  logic [15:0] cmd_wdata, resp_data, rise, fall, en, ev, got, prev;
  logic [2:0]  zero_sel [5] = '{3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
  int          err_total = 0, total_checks = 0, seed = 32'h0972d18c;
  // ****************************
  // harness
  // ****************************
  initial forever #5 clk_i = ~clk_i;
  op_status_group u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .prog_running_i(prog),
    .call_summary_i(call), .cmd_write_i(cmd_write), .cmd_query_i(cmd_query),
    .cmd_sel_i(cmd_sel), .cmd_wdata_i(cmd_wdata), .clear_status_i(clear_status),
    .reset_cmd_i(reset_cmd), .resp_valid_o(resp_valid), .resp_data_o(resp_data),
    .summary_o(summary));
  op_host_model u_host (.clk_i(clk_i), .resp_valid_i(resp_valid), .resp_data_i(resp_data),
    .cmd_write_o(cmd_write), .cmd_query_o(cmd_query), .cmd_sel_o(cmd_sel),
    .cmd_wdata_o(cmd_wdata), .clear_status_o(clear_status), .reset_cmd_o(reset_cmd));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done();
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  function automatic logic [15:0] cond_of(input logic p, input logic c);
    return {1'b0, p, 4'h0, c, 9'h0};
  endfunction : cond_of
  // sticky: a set bit stays set whatever the input does next
  function automatic logic [15:0] ev_next(input logic [15:0] e, p, c);
    return (e | (rise & c & ~p) | (fall & ~c & p)) & USED_MASK;
  endfunction : ev_next
  // ****************************
  // scenarios
  // ****************************
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    u_host.qry(SEL_RISE, got); check("rise", got, RISE_RESET);
    u_host.qry(SEL_FALL, got); check("fall", got, FALL_RESET);
    u_host.qry(SEL_ENABLE, got); check("enable", got, ENABLE_RESET);
    u_host.wr(SEL_CONDITION, 16'hffff);
    foreach (zero_sel[k]) begin
      u_host.qry(zero_sel[k], got); check("idle", got, 16'h0);
    end
    for (int i = 0; i < 12; i++) begin
      rise = $random(seed);
      fall = $random(seed);
      en   = $random(seed);
      if (i == 0) {rise, fall, en} = '1;
      u_host.wr(SEL_RISE, rise);
      u_host.wr(SEL_FALL, fall);
      u_host.wr(SEL_ENABLE, en);
      u_host.clr(1'b0);
      ev = '0;
      u_host.qry(SEL_RISE, got); check("rise", got, rise);
      u_host.qry(SEL_FALL, got); check("fall", got, fall);
      u_host.qry(SEL_ENABLE, got); check("enable", got, en & USED_MASK);
      for (int j = 0; j < 6; j++) begin
        prev = cond_of(prog, call);
        @(posedge clk_i);
        {prog, call} <= 2'($random(seed));
        repeat (2) @(posedge clk_i);
        #1;
        ev = ev_next(ev, prev, cond_of(prog, call));
        check("summary", {15'h0, summary}, {15'h0, |(ev & en)});
      end
      u_host.qry(SEL_CONDITION, got); check("cond", got, cond_of(prog, call));
      // every other round clear-status wipes the latched events before the query
      if (i % 2 == 1) begin
        u_host.clr(1'b0);
        ev = '0;
        #1;
        check("summary", {15'h0, summary}, 16'h0);
      end
      u_host.qry(SEL_EVENT, got); check("event", got, ev);
      u_host.qry(SEL_EVENT, got); check("event", got, 16'h0);
    end
    u_host.clr(1'b1);
    u_host.qry(SEL_RISE, got); check("rise", got, RISE_RESET);
    u_host.qry(SEL_FALL, got); check("fall", got, FALL_RESET);
    u_host.qry(SEL_ENABLE, got); check("enable", got, en & USED_MASK);
    // power-on reset in mid-run with both inputs high: enable returns to its reset
    // value, and since the previous condition restarts at zero the release is a rise
    resetn_i <= 1'b0;
    {prog, call} <= 2'b11;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    {rise, fall} = {RISE_RESET, FALL_RESET};
    ev = ev_next(16'h0, 16'h0, cond_of(1'b1, 1'b1));
    u_host.qry(SEL_ENABLE, got); check("enable", got, ENABLE_RESET);
    u_host.qry(SEL_RISE, got); check("rise", got, RISE_RESET);
    u_host.qry(SEL_EVENT, got); check("event", got, ev);
    test_done();
  end
  // whole run needs well under ten thousand clocks
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule : op_status_group_tb_top
